// *** hw/sdram_boot_locked_config_map.svh ***
// Offsets, field positions, reset values and bus codes of the boot-locked configuration register
`ifndef SDRAM_BOOT_LOCKED_CONFIG_MAP_SVH
`define SDRAM_BOOT_LOCKED_CONFIG_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define SDRAM_CONFIG_OFFSET 32'h0000_0000

// ****************************************
// Field positions
// ****************************************
`define TERMINATION_HI_BIT 27
`define DRIVE_STRENGTH_HI_BIT 24
`define BOOT_FIELD_UNLOCK_BIT 23
`define DIFF_STROBE_SELECT_BIT 22
`define TERMINATION_LO_BIT 21
`define DDR2_MODE_ENABLE_BIT 20
`define MEM_DLL_DISABLE_BIT 19
`define DRIVE_STRENGTH_LO_BIT 18

// ****************************************
// Reset values
// ****************************************
`define TERMINATION_RST 2'h2
`define DRIVE_STRENGTH_RST 2'h0
`define BOOT_FIELD_UNLOCK_RST 1'h0
`define DIFF_STROBE_SELECT_RST 1'h0
`define DDR2_MODE_ENABLE_RST 1'h0
`define MEM_DLL_DISABLE_RST 1'h0

// ****************************************
// Bus response codes
// ****************************************
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_DECERR 2'h3

`endif

// *** hw/sdram_boot_locked_config_pkg.sv ***
// Types shared by the boot-locked configuration register files
package sdram_boot_locked_config_pkg;

    // ****************************************
    // Protected configuration fields
    // ****************************************
    typedef struct packed {
        logic [1:0] termination;
        logic [1:0] drive_strength;
        logic diff_strobe_select;
        logic ddr2_mode_enable;
        logic mem_dll_disable;
        logic boot_field_unlock;
    } cfg_fields_t;

    // ****************************************
    // Bus state machines
    // ****************************************
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_t;

endpackage

// *** hw/boot_unlock_gate.sv ***
// Two-step unlock gate that decides the next value of the protected fields
`timescale 1ns/1ns
`include "sdram_boot_locked_config_map.svh"
module boot_unlock_gate
(
    // Current fields
    input sdram_boot_locked_config_pkg::cfg_fields_t cur,
    // Write carrying merged register word
    input wire logic [31:0] word,
    input wire logic apply_en,
    // Resulting fields
    output sdram_boot_locked_config_pkg::cfg_fields_t nxt
);
    import sdram_boot_locked_config_pkg::*;

    always_comb
    begin
        nxt = cur;
        if (apply_en)
        begin
            if (word[`BOOT_FIELD_UNLOCK_BIT])
            begin
                // Opening write only sets the unlock bit; fields keep their value
                nxt.boot_field_unlock = 1'b1;
            end
            else if (cur.boot_field_unlock)
            begin
                // Closing write loads every protected field and relocks
                nxt.termination = {word[`TERMINATION_HI_BIT], word[`TERMINATION_LO_BIT]};
                nxt.drive_strength = {word[`DRIVE_STRENGTH_HI_BIT], word[`DRIVE_STRENGTH_LO_BIT]};
                nxt.diff_strobe_select = word[`DIFF_STROBE_SELECT_BIT];
                nxt.ddr2_mode_enable = word[`DDR2_MODE_ENABLE_BIT];
                nxt.mem_dll_disable = word[`MEM_DLL_DISABLE_BIT];
                nxt.boot_field_unlock = 1'b0;
            end
            else
            begin
                // Locked: the write is dropped for protected fields
                nxt = cur;
            end
        end
    end

endmodule

// *** hw/sdram_boot_locked_config.sv ***
// AXI4-Lite register bank holding the boot-locked memory configuration fields
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`include "sdram_boot_locked_config_map.svh"

module sdram_boot_locked_config
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Memory type enables held elsewhere in the controller
    input wire logic double_rate_enable,
    input wire logic sync_dram_enable,
    // Configuration toward the memory interface
    output sdram_boot_locked_config_pkg::cfg_fields_t cfg_out,
    output logic ddr2_selected
);
    import sdram_boot_locked_config_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        wr_state_t wr_state;
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [31:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        rd_state_t rd_state;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        cfg_fields_t cfg;
        logic ddr2_selected;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    cfg_fields_t gated_cfg;
    logic [31:0] merged_word;
    logic write_apply;

    // ****************************************
    // Helpers
    // ****************************************
    // Word decode shared by both channels; low two address bits are ignored
    function automatic logic hits_config(input logic [31:0] addr);
        logic [31:0] base;
        base = `SDRAM_CONFIG_OFFSET;
        hits_config = (addr[31:2] == base[31:2]);
    endfunction

    // Place the fields at their bit positions; reserved and foreign bits read zero
    function automatic logic [31:0] pack_cfg(input cfg_fields_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`TERMINATION_HI_BIT] = c.termination[1];
        w[`DRIVE_STRENGTH_HI_BIT] = c.drive_strength[1];
        w[`BOOT_FIELD_UNLOCK_BIT] = c.boot_field_unlock;
        w[`DIFF_STROBE_SELECT_BIT] = c.diff_strobe_select;
        w[`TERMINATION_LO_BIT] = c.termination[0];
        w[`DDR2_MODE_ENABLE_BIT] = c.ddr2_mode_enable;
        w[`MEM_DLL_DISABLE_BIT] = c.mem_dll_disable;
        w[`DRIVE_STRENGTH_LO_BIT] = c.drive_strength[0];
        pack_cfg = w;
    endfunction

    // Byte lanes without a strobe keep the stored value
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_w, input logic [31:0] new_w,
                                                input logic [3:0] strb);
        logic [31:0] m;
        m = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                m[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        merge_lanes = m;
    endfunction

    // ****************************************
    // Unlock gate
    // ****************************************
    assign merged_word = merge_lanes(pack_cfg(st_r.cfg), st_r.wdata, st_r.wstrb);
    assign write_apply = (st_r.wr_state == WR_COLLECT) && st_r.aw_held && st_r.w_held && hits_config(st_r.waddr);

    boot_unlock_gate u_gate
    (
        .cur(st_r.cfg),
        .word(merged_word),
        .apply_en(write_apply),
        .nxt(gated_cfg)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;

        // Write channel
        case (st_r.wr_state)
            WR_COLLECT:
            begin
                if (s_axi_awvalid && st_r.awready)
                begin
                    st_nxt.waddr = s_axi_awaddr;
                    st_nxt.aw_held = 1'b1;
                    st_nxt.awready = 1'b0;
                end
                else if (!st_r.aw_held)
                begin
                    st_nxt.awready = 1'b1;
                end
                if (s_axi_wvalid && st_r.wready)
                begin
                    st_nxt.wdata = s_axi_wdata;
                    st_nxt.wstrb = s_axi_wstrb;
                    st_nxt.w_held = 1'b1;
                    st_nxt.wready = 1'b0;
                end
                else if (!st_r.w_held)
                begin
                    st_nxt.wready = 1'b1;
                end
                if (st_r.aw_held && st_r.w_held)
                begin
                    // Config update lands on the same edge that raises bvalid
                    st_nxt.cfg = gated_cfg;
                    st_nxt.bresp = hits_config(st_r.waddr) ? `AXI_RESP_OKAY : `AXI_RESP_DECERR;
                    st_nxt.bvalid = 1'b1;
                    st_nxt.wr_state = WR_RESP;
                end
            end
            WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    st_nxt.bvalid = 1'b0;
                    st_nxt.aw_held = 1'b0;
                    st_nxt.w_held = 1'b0;
                    st_nxt.awready = 1'b1;
                    st_nxt.wready = 1'b1;
                    st_nxt.wr_state = WR_COLLECT;
                end
            end
            default:
            begin
                st_nxt.wr_state = WR_COLLECT;
                st_nxt.aw_held = 1'b0;
                st_nxt.w_held = 1'b0;
                st_nxt.bvalid = 1'b0;
            end
        endcase

        // Read channel; a read racing a write sees the value before the write
        case (st_r.rd_state)
            RD_IDLE:
            begin
                st_nxt.arready = 1'b1;
                if (s_axi_arvalid && st_r.arready)
                begin
                    st_nxt.arready = 1'b0;
                    st_nxt.rvalid = 1'b1;
                    if (hits_config(s_axi_araddr))
                    begin
                        st_nxt.rdata = pack_cfg(st_r.cfg);
                        st_nxt.rresp = `AXI_RESP_OKAY;
                    end
                    else
                    begin
                        st_nxt.rdata = 32'h0000_0000;
                        st_nxt.rresp = `AXI_RESP_DECERR;
                    end
                    st_nxt.rd_state = RD_DATA;
                end
            end
            RD_DATA:
            begin
                if (s_axi_rready)
                begin
                    st_nxt.rvalid = 1'b0;
                    st_nxt.arready = 1'b1;
                    st_nxt.rd_state = RD_IDLE;
                end
            end
            default:
            begin
                st_nxt.rd_state = RD_IDLE;
                st_nxt.rvalid = 1'b0;
                st_nxt.arready = 1'b0;
            end
        endcase

        // Memory is DDR2 only when all three type enables are set
        st_nxt.ddr2_selected = st_nxt.cfg.ddr2_mode_enable && double_rate_enable && sync_dram_enable;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r.wr_state <= WR_COLLECT;
            st_r.awready <= 1'b0;
            st_r.wready <= 1'b0;
            st_r.aw_held <= 1'b0;
            st_r.w_held <= 1'b0;
            st_r.waddr <= 32'h0000_0000;
            st_r.wdata <= 32'h0000_0000;
            st_r.wstrb <= 4'h0;
            st_r.bvalid <= 1'b0;
            st_r.bresp <= `AXI_RESP_OKAY;
            st_r.rd_state <= RD_IDLE;
            st_r.arready <= 1'b0;
            st_r.rvalid <= 1'b0;
            st_r.rresp <= `AXI_RESP_OKAY;
            st_r.rdata <= 32'h0000_0000;
            // Termination comes up enabled; software must clear it
            st_r.cfg.termination <= `TERMINATION_RST;
            st_r.cfg.drive_strength <= `DRIVE_STRENGTH_RST;
            st_r.cfg.diff_strobe_select <= `DIFF_STROBE_SELECT_RST;
            st_r.cfg.ddr2_mode_enable <= `DDR2_MODE_ENABLE_RST;
            st_r.cfg.mem_dll_disable <= `MEM_DLL_DISABLE_RST;
            st_r.cfg.boot_field_unlock <= `BOOT_FIELD_UNLOCK_RST;
            st_r.ddr2_selected <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rvalid = st_r.rvalid;
    // Drive and termination codes pass through untranslated to the mode register logic
    assign cfg_out = st_r.cfg;
    assign ddr2_selected = st_r.ddr2_selected;

endmodule

// *** sim/sdram_boot_locked_config_properties.sv ***
// Port-level checks of the boot-locked configuration register
`timescale 1ns/1ns
module sdram_boot_locked_config_properties
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register bus
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Memory type and configuration
    input wire logic double_rate_enable,
    input wire logic sync_dram_enable,
    input sdram_boot_locked_config_pkg::cfg_fields_t cfg_out,
    input wire logic ddr2_selected
);
    import sdram_boot_locked_config_pkg::*;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // ********
    // Checks
    // ********
    function automatic logic [31:0] word_of(cfg_fields_t c);
        return {4'h0, c.termination[1], 2'h0, c.drive_strength[1], c.boot_field_unlock, c.diff_strobe_select,
            c.termination[0], c.ddr2_mode_enable, c.mem_dll_disable, c.drive_strength[0], 18'h0};
    endfunction

    property p_reset_value;
        $fell(sys_rst) |-> cfg_out == 8'h80;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("config not at reset value");
    property p_locked;
        !$stable(cfg_out[7:1]) |-> $past(cfg_out.boot_field_unlock);
    endproperty
    a_locked: assert property (p_locked) else $error("field changed while locked");
    property p_unlock_keeps;
        $rose(cfg_out.boot_field_unlock) |-> $stable(cfg_out[7:1]);
    endproperty
    a_unlock_keeps: assert property (p_unlock_keeps) else $error("unlock write moved a field");
    property p_change_with_resp;
        !$stable(cfg_out) |-> $rose(s_axi_bvalid);
    endproperty
    a_change_with_resp: assert property (p_change_with_resp) else $error("config moved without a write");
    property p_write_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid &&
            s_axi_bresp == (($past(s_axi_awaddr[31:2], 2) == 30'h0) ? 2'h0 : 2'h3);
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write response wrong");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_read_map;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[31:2] == 30'h0 |=>
            s_axi_rvalid && s_axi_rresp == 2'h0 && s_axi_rdata == word_of($past(cfg_out));
    endproperty
    a_read_map: assert property (p_read_map) else $error("read word wrong");
    property p_read_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[31:2] != 30'h0 |=>
            s_axi_rvalid && s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read answered");
    property p_ddr2_sel;
        ddr2_selected == (cfg_out.ddr2_mode_enable & $past(double_rate_enable) & $past(sync_dram_enable));
    endproperty
    a_ddr2_sel: assert property (p_ddr2_sel) else $error("memory type select wrong");
endmodule

bind sdram_boot_locked_config sdram_boot_locked_config_properties u_props
(
    .mclk, .sys_rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .double_rate_enable, .sync_dram_enable, .cfg_out, .ddr2_selected
);

// *** sim/tb_top.sv ***
// Self-checking bench of the boot-locked configuration register
`timescale 1ns/1ns
module tb_top;
    import sdram_boot_locked_config_pkg::*;
    logic mclk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ddr2_selected;
    logic double_rate_enable, sync_dram_enable;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] seed;
    logic [33:0] wq[$];
    logic [33:0] rq[$];
    cfg_fields_t cfg_out, exp_cfg;
    int bad_count, compares, cycles;

    sdram_boot_locked_config DUT
    (
        .mclk, .sys_rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .double_rate_enable, .sync_dram_enable, .cfg_out, .ddr2_selected
    );

    always #5 mclk = ~mclk;

    // ********
    // Helpers
    // ********
    function automatic logic [31:0] word_of(cfg_fields_t c);
        return {4'h0, c.termination[1], 2'h0, c.drive_strength[1], c.boot_field_unlock, c.diff_strobe_select,
            c.termination[0], c.ddr2_mode_enable, c.mem_dll_disable, c.drive_strength[0], 18'h0};
    endfunction

    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic chk(string what, logic [33:0] e, logic [33:0] g);
        compares++;
        if (e !== g)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Model follows the merged word, so a lane left out keeps the stored unlock bit
    task automatic axi_write(logic [31:0] a, logic [31:0] dat, logic [3:0] s, int stall);
        logic [31:0] m;
        logic aw_done;
        logic w_done;
        logic dre;
        logic sde;
        m = word_of(exp_cfg);
        seed = lfsr(seed);
        dre = seed[0] | seed[1];
        sde = seed[2] | seed[3];
        for (int b = 0; b < 4; b++)
            if (s[b])
                m[8 * b +: 8] = dat[8 * b +: 8];
        if (a[31:2] == 30'h0 && m[23])
            exp_cfg.boot_field_unlock = 1'b1;
        else if (a[31:2] == 30'h0 && exp_cfg.boot_field_unlock)
            exp_cfg = {m[27], m[21], m[24], m[18], m[22], m[20], m[19], 1'b0};
        wq.push_back({(a[31:2] == 30'h0) ? 2'h0 : 2'h3, 23'h0, exp_cfg, exp_cfg.ddr2_mode_enable & dre & sde});
        @(posedge mclk);
        double_rate_enable <= dre;
        sync_dram_enable <= sde;
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        while (!(aw_done && w_done))
        begin
            @(posedge mclk);
            if (!aw_done && s_axi_awready)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        repeat (stall) @(posedge mclk);
        s_axi_bready <= 1'b1;
        do @(posedge mclk); while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(logic [31:0] a);
        rq.push_back({(a[31:2] == 30'h0) ? 2'h0 : 2'h3, (a[31:2] == 30'h0) ? word_of(exp_cfg) : 32'h0});
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    // ********
    // Result watcher
    // ********
    always @(posedge mclk)
    begin
        if (!sys_rst && s_axi_bvalid && s_axi_bready)
            chk("write result", wq.size() > 0 ? wq.pop_front() : {34{1'bx}},
                {s_axi_bresp, 23'h0, cfg_out, ddr2_selected});
        if (!sys_rst && s_axi_rvalid && s_axi_rready)
            chk("read result", rq.size() > 0 ? rq.pop_front() : {34{1'bx}}, {s_axi_rresp, s_axi_rdata});
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            bad_count++;
            close_out;
        end
    end

    // ********
    // Scenarios
    // ********
    initial
    begin
        {mclk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {double_rate_enable, sync_dram_enable} = 2'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
        sys_rst = 1'b1;
        exp_cfg = 8'h80;
        seed = 16'h8950;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        axi_read(32'h0);
        axi_write(32'h0, 32'hFF7F_FFFF, 4'hF, 0);
        axi_write(32'h0, 32'hFFFF_FFFF, 4'hF, 2);
        axi_read(32'h0);
        for (int i = 0; i < 8; i++)
        begin
            axi_write(32'h0, 32'h0080_0000, 4'h4, 0);
            d = ({seed, seed} & 32'hF65B_FFFF) | {4'h0, i[0], 2'h0, i[1], 2'h0, i[1], 2'h0, i[0], 18'h0};
            axi_write(32'h0, d, 4'hF, i % 3);
            axi_read(32'h0);
        end
        // Lanes left out keep the stored unlock bit, so the two partial writes after the opening one stay unlock writes
        axi_write(32'h0, 32'h0080_0000, 4'hF, 0);
        axi_write(32'h0, 32'h0000_FFFF, 4'h3, 1);
        axi_write(32'h0, 32'h0900_0000, 4'h8, 0);
        axi_write(32'h0, 32'h0000_0000, 4'hF, 0);
        axi_write(32'h0, 32'hFF00_0000, 4'h8, 0);
        axi_write(32'h4, 32'h0080_0000, 4'hF, 0);
        axi_write(32'h0, 32'h0010_0000, 4'hF, 0);
        axi_read(32'h8);
        axi_write(32'h0, 32'h0080_0000, 4'hF, 0);
        axi_write(32'h0, 32'h0814_0000, 4'hF, 0);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        exp_cfg = 8'h80;
        repeat (2) @(posedge mclk);
        axi_read(32'h0);
        repeat (4) @(posedge mclk);
        close_out;
    end
endmodule
